// file: design/power_good_thermal_trip_ctrl.sv
// Functional notes
// - Power-good synchronised through a two-stage chain, also in lockstep redundancy mode.
// - Temperature over trip point halts execution and asserts trip output.
// - Trip output and halt stay until reset input asserts or power-good drops.
// - No hysteresis; reset while cool clears trip and resumes execution.
// - Reset while still hot keeps trip output asserted and halted.
module power_good_thermal_trip_ctrl (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic power_ok_in,
	input wire logic over_temp_in,
	input wire logic lockstep_redundancy_mode_in,
	output logic overtemp_halt_n_out,
	output logic exec_halt_out,
	output logic core_rst_n_out
);
	logic [1:0] pok_sync;
	logic [1:0] hot_sync;
	logic [1:0] rstreq_sync;
	logic [1:0] next_pok_sync;
	logic [1:0] next_hot_sync;
	logic [1:0] next_rstreq_sync;
	logic pok_level;
	logic hot_level;
	logic rst_pin_req;
	logic int_rst_n;
	logic trip_active;
	logic next_halt;
	logic next_trip_n;
	logic next_core_rst_n;
	pg_trip_pkg::state_t state;
	pg_trip_pkg::state_t next_state;
	trip_if t ();

	// Shift values for the three two-stage chains
	always_comb begin
		next_pok_sync = {pok_sync[0], power_ok_in};
		next_hot_sync = {hot_sync[0], over_temp_in};
		next_rstreq_sync = {rstreq_sync[0], 1'b0};
	end

	// Power-good chain; lockstep mode needs no extra handling
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pok_sync <= pg_trip_pkg::sync_reset;
		end else begin
			pok_sync <= next_pok_sync;
		end
	end

	// Sensor chain keeps sampling through a reset pulse
	always_ff @(posedge clk_in) begin
		hot_sync <= next_hot_sync;
	end

	// Reset pin shows as a request for two edges after release
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rstreq_sync <= 2'h3;
		end else begin
			rstreq_sync <= next_rstreq_sync;
		end
	end

	assign pok_level = pok_sync[1];
	assign hot_level = hot_sync[1];
	assign rst_pin_req = rstreq_sync[1];
	assign int_rst_n = nrst_in & pok_level;
	assign trip_active = t.tripped | hot_level;
	assign t.hot = hot_level;
	assign t.rst_req = rst_pin_req | ~pok_level;

	trip_latch u_latch (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.t(t)
	);

	// Run, halt and trip controller
	always_comb begin
		next_state = state;
		case (state)
			pg_trip_pkg::st_off: begin
				if (!pok_level) begin
					next_state = pg_trip_pkg::st_off;
				end else if (trip_active) begin
					next_state = pg_trip_pkg::st_tripped;
				end else begin
					next_state = pg_trip_pkg::st_run;
				end
			end

			pg_trip_pkg::st_run: begin
				if (!pok_level) begin
					next_state = pg_trip_pkg::st_off;
				end else if (trip_active) begin
					next_state = pg_trip_pkg::st_tripped;
				end else begin
					next_state = pg_trip_pkg::st_run;
				end
			end

			pg_trip_pkg::st_tripped: begin
				if (trip_active) begin
					next_state = pg_trip_pkg::st_tripped;
				end else if (pok_level) begin
					next_state = pg_trip_pkg::st_run;
				end else begin
					next_state = pg_trip_pkg::st_off;
				end
			end

			default: begin
				next_state = pg_trip_pkg::st_off;
			end
		endcase
	end

	// Halt follows the controller's next state
	always_comb begin
		case (next_state)
			pg_trip_pkg::st_run: begin
				next_halt = 1'b0;
			end

			pg_trip_pkg::st_tripped: begin
				next_halt = 1'b1;
			end

			default: begin
				next_halt = 1'b1;
			end
		endcase
	end

	// Trip pin level
	always_comb begin
		if (trip_active) begin
			next_trip_n = 1'b0;
		end else begin
			next_trip_n = 1'b1;
		end
	end

	// Core reset level
	always_comb begin
		if (int_rst_n) begin
			next_core_rst_n = 1'b1;
		end else begin
			next_core_rst_n = 1'b0;
		end
	end

	// Controller state
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state <= pg_trip_pkg::st_off;
		end else begin
			state <= next_state;
		end
	end

	// Execution halt to the core
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			exec_halt_out <= pg_trip_pkg::halt_reset;
		end else begin
			exec_halt_out <= next_halt;
		end
	end

	// Trip pin has no reset: a reset pulse while hot keeps it driven
	always_ff @(posedge clk_in) begin
		overtemp_halt_n_out <= next_trip_n;
	end

	// Core reset held while power-good is low
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			core_rst_n_out <= 1'b0;
		end else begin
			core_rst_n_out <= next_core_rst_n;
		end
	end
endmodule

// file: design/trip_latch.sv
// Sticky over-temperature latch, cleared only by reset or power-good loss when cool
module trip_latch (
	input wire logic clk_in,
	input wire logic nrst_in,
	trip_if.latch t
);
	logic tripped;

	// No async clear: a reset pulse while hot must not drop the trip
	always_ff @(posedge clk_in) begin
		if (t.hot) begin
			tripped <= 1'b1;
		end else if (t.rst_req || !nrst_in) begin
			tripped <= pg_trip_pkg::trip_reset;
		end
	end
	assign t.tripped = tripped;
endmodule

// file: dv/pg_supply_model.sv
// Supply monitor and reset source
module pg_supply_model (input logic clk_in, input logic [1:0] cmd_in,
	output logic power_ok_out = 0, output logic nrst_out = 0);
	timeunit 1ns / 1ps;
	always @(posedge clk_in) if (cmd_in != 0) begin
		power_ok_out <= !cmd_in[1];
		repeat (6) @(posedge clk_in);
		power_ok_out <= 1;
		nrst_out <= 0;
		repeat (2) @(posedge clk_in);
		nrst_out <= 1;
	end
endmodule

// file: dv/pg_trip_monitor.sv
// Power-good and trip checker
module pg_trip_monitor (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic power_ok_in,
	input wire logic over_temp_in,
	input wire logic overtemp_halt_n_out,
	input wire logic exec_halt_out,
	input wire logic core_rst_n_out
);
	timeunit 1ns / 1ps;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	a_trip_sets:
		assert property (over_temp_in[*3] |-> ##[1:4] !overtemp_halt_n_out) else $error("trip");
	a_trip_holds:
		assert property (power_ok_in[*6] ##0 !overtemp_halt_n_out |=> !overtemp_halt_n_out)
			else $error("held");
	a_cool_run:
		assert property ((power_ok_in && overtemp_halt_n_out)[*8] |-> !exec_halt_out) else $error("run");
	a_pg_holds:
		assert property ((!power_ok_in)[*5] |-> !core_rst_n_out && exec_halt_out) else $error("pg");
	a_halt_on_trip:
		assert property (!overtemp_halt_n_out |-> exec_halt_out) else $error("halt");
	a_core_rst_halt:
		assert property (!core_rst_n_out |-> exec_halt_out) else $error("core");
	a_hot_keeps_trip:
		assert property (disable iff (1'b0)
			over_temp_in[*3] ##0 !overtemp_halt_n_out |=> !overtemp_halt_n_out) else $error("kept");
	cover property (!overtemp_halt_n_out);
	cover property (!exec_halt_out);
	cover property (!core_rst_n_out);
endmodule
bind power_good_thermal_trip_ctrl pg_trip_monitor u_mon (.*);

// file: dv/power_good_thermal_trip_ctrl_tb.sv
// Power-good and trip bench
module power_good_thermal_trip_ctrl_tb;
	timeunit 1ns / 1ps;
	logic clk_in = 0, over_temp_in = 0, lockstep_redundancy_mode_in = 0;
	logic [1:0] cmd = 0;
	logic [2:0] q[$];
	wire power_ok_in, nrst_in, overtemp_halt_n_out, exec_halt_out, core_rst_n_out;
	int miscompares = 0, comparisons = 0, seed = 32'hbb6f;
	initial forever #2.5 clk_in = ~clk_in;
	pg_supply_model u_sys (.clk_in, .cmd_in(cmd), .power_ok_out(power_ok_in), .nrst_out(nrst_in));
	power_good_thermal_trip_ctrl u_dut (.*);
	task automatic check(input logic [2:0] s, e);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %0t %b", $time, s);
		end
	endtask
	task automatic final_report;
		$display("miscompares %0d comparisons %0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic step(input logic [1:0] c, input logic h, input logic [2:0] e);
		@(posedge clk_in) {cmd, over_temp_in, lockstep_redundancy_mode_in} <= {c, h, 1'($random(seed))};
		@(posedge clk_in) cmd <= 0;
		repeat (40) @(posedge clk_in);
		q.push_back(e);
	endtask
	always @(posedge clk_in) if (q.size())
		check({overtemp_halt_n_out, exec_halt_out, core_rst_n_out}, q.pop_front());
	initial begin
		step(2, 0, 3'h5);
		step(0, 1, 3'h3);
		step(0, 0, 3'h3);
		step(1, 1, 3'h3);
		step(1, 0, 3'h5);
		step(2, 0, 3'h5);
		repeat (2) @(posedge clk_in);
		final_report;
	end
	initial begin
		#2000 miscompares++;
		final_report;
	end
endmodule

// file: include/pg_trip_pkg.sv
// Constants shared by the power-good and thermal-trip block
package pg_trip_pkg;
	localparam int unsigned clk_mhz = 200;
	localparam int unsigned sync_stages = 2;
	localparam logic [1:0] sync_reset = 2'h0;
	localparam logic trip_reset = 1'h0;
	localparam logic halt_reset = 1'h1;
	localparam logic trip_n_reset = 1'h1;
	typedef enum logic [1:0] {st_off, st_run, st_tripped} state_t;
endpackage

// file: include/trip_if.sv
// Carries synchronised sensor and reset levels to the trip latch
interface trip_if;
	logic hot;
	logic rst_req;
	logic tripped;
	modport src (output hot, output rst_req, input tripped);
	modport latch (input hot, input rst_req, output tripped);
endinterface
